// ---- verilog/pab_pkg.sv ----
/*
 * Constants for the port A / port B alternate function override block:
 * pin counts, pin positions of each shared function, reset values and
 * the serial interface role encoding.
 * Assumes a single clock domain and that every consumer imports pab_pkg::*.
 */
package pab_pkg;

	// Pin counts
	localparam int unsigned PAB_PORT_W   = 8;               // Pins per port
	localparam int unsigned PAB_NUM_PINS = 2 * PAB_PORT_W;  // Port A then port B
	localparam int unsigned PAB_PB_BASE  = PAB_PORT_W;      // First port B index in the pin vector

	// Port B pin positions
	localparam int unsigned PAB_PB_SPI_CLK = 7;             // Serial clock
	localparam int unsigned PAB_PB_SPI_CI  = 6;             // Controller in / target out
	localparam int unsigned PAB_PB_SPI_CO  = 5;             // Controller out / target in
	localparam int unsigned PAB_PB_SPI_SEL = 4;             // Target select
	localparam int unsigned PAB_PB_CMP0    = 3;             // Compare output / comparator neg
	localparam int unsigned PAB_PB_IRQ2    = 2;             // Interrupt 2 / comparator pos
	localparam int unsigned PAB_PB_CNT1    = 1;             // Counter 1 source
	localparam int unsigned PAB_PB_CNT0    = 0;             // Counter 0 source / USART clock

	// Reset values
	localparam logic [PAB_PORT_W-1:0]   PAB_RST_PORT = 8'h00;   // Per-port registers
	localparam logic [PAB_NUM_PINS-1:0] PAB_RST_PINS = 16'h0000; // Full pin vectors
	localparam logic                    PAB_RST_BIT  = 1'h0;    // Single-bit registers

	// Override value driven onto the direction path by every serial pin
	localparam logic PAB_SPI_DIR_OVR_VAL = 1'h0;

	// Serial interface role
	typedef enum logic [1:0] {
		PAB_SPI_OFF,
		PAB_SPI_CTRL,
		PAB_SPI_TGT
	} pab_spi_role_e;

endpackage

// ---- verilog/pab_pin_ctrl.sv ----
/*
 * Generic per-pin override resolver: merges the port register bits with
 * the override enables and values from one alternate function.
 * Purely combinational; the caller registers whatever reaches the pad.
 */
`timescale 1ns/1ps
module pab_pin_ctrl (
	// Port register side
	input  wire logic dir_bit_i,               // Direction register bit
	input  wire logic out_bit_i,               // Output register bit
	input  wire logic global_pullup_off_i,     // Global pull-up disable
	input  wire logic deep_sleep_i,            // Processor in a deep sleep mode
	// Overrides from the alternate function
	input  wire logic pullup_override_en_i,
	input  wire logic pullup_override_val_i,
	input  wire logic dir_override_en_i,
	input  wire logic dir_override_val_i,
	input  wire logic value_override_en_i,
	input  wire logic value_override_val_i,
	input  wire logic input_buf_override_en_i,
	input  wire logic input_buf_override_val_i,
	// Pad side
	input  wire logic pad_level_i,             // Raw pad level
	output logic      pullup_en_o,             // Pull-up switched on
	output logic      drive_en_o,              // Output driver enabled
	output logic      drive_val_o,             // Level driven when enabled
	output logic      pin_input_to_function_o  // Digital input, clamped when disabled
);
	import pab_pkg::*;

	// Plain pull-up: input with output bit set and pull-ups globally allowed
	logic plain_pullup;   // Pull-up without override
	logic input_en;       // Digital input enable after override

	assign plain_pullup = ~dir_bit_i & out_bit_i & ~global_pullup_off_i;

	// Override selects the pull-up source
	assign pullup_en_o = pullup_override_en_i ? pullup_override_val_i : plain_pullup;

	// Direction override takes the driver away from the direction bit
	assign drive_en_o = dir_override_en_i ? dir_override_val_i : dir_bit_i;

	// Value override replaces the output register bit
	assign drive_val_o = value_override_en_i ? value_override_val_i : out_bit_i;

	// Input buffer: override wins over the sleep clamp
	assign input_en = input_buf_override_en_i ? input_buf_override_val_i : ~deep_sleep_i;

	// Clamped to ground when the buffer is off, so floating pads cost no current
	assign pin_input_to_function_o = pad_level_i & input_en;

endmodule // pab_pin_ctrl

// ---- verilog/pab_port_mux.sv ----
/* Alternate function override logic for two 8-bit ports (A and B).
 * Holds the per-pin override tables, resolves them through one
 * pab_pin_ctrl per pin and registers everything that leaves the block.
 * Assumes port registers, peripherals and pads are synchronous to sys_clk_i. */
// Summary of operation
// - Port A overrides all zero; analog path only
// - Target role forces clock pin to input
// - Controller role forces pin 6 to input
// - Target role forces pin 5 to input
// - Target select forced input; active while low
// - Forced-input pull-up follows output bit, gated
// - Pin 6: controller input, target output
// - Pin 5: controller output, target input; pin 7 clock out
// - Compare output drives pin 3 when enabled and direction bit set
// - Interrupt 2 forces input buffer on
// - Pin 1 feeds counter 1, no overrides
// - Pin 0 feeds counter 0 and USART clock
// - Pin 0 direction bit picks clock direction
// - USART clock only in synchronous mode
// - Global pull-up disable turns pull-ups off
// - Direction override selects driver enable
// - Value override replaces driven level
// - Input buffer override beats sleep clamp
`timescale 1ns/1ps
module pab_port_mux (
	// Clock and reset
	input  wire logic                          sys_clk_i,
	input  wire logic                          rst_b_i,
	// Port A register bits and pads
	input  wire logic [pab_pkg::PAB_PORT_W-1:0] port_a_direction_bits_i,
	input  wire logic [pab_pkg::PAB_PORT_W-1:0] port_a_output_bits_i,
	input  wire logic [pab_pkg::PAB_PORT_W-1:0] port_a_pad_i,
	output logic      [pab_pkg::PAB_PORT_W-1:0] port_a_pad_o,
	output logic      [pab_pkg::PAB_PORT_W-1:0] port_a_pad_oe_o,
	output logic      [pab_pkg::PAB_PORT_W-1:0] port_a_pullup_o,
	output logic      [pab_pkg::PAB_PORT_W-1:0] port_a_pin_read_o,
	// Port B register bits and pads
	input  wire logic [pab_pkg::PAB_PORT_W-1:0] port_b_direction_bit_i,
	input  wire logic [pab_pkg::PAB_PORT_W-1:0] port_b_output_bit_i,
	input  wire logic [pab_pkg::PAB_PORT_W-1:0] port_b_pad_i,
	output logic      [pab_pkg::PAB_PORT_W-1:0] port_b_pad_o,
	output logic      [pab_pkg::PAB_PORT_W-1:0] port_b_pad_oe_o,
	output logic      [pab_pkg::PAB_PORT_W-1:0] port_b_pullup_o,
	output logic      [pab_pkg::PAB_PORT_W-1:0] port_b_pin_read_o,
	// Global controls
	input  wire logic                          global_pullup_off_i,
	input  wire logic                          deep_sleep_i,
	// Analog converter channels
	output logic      [pab_pkg::PAB_PORT_W-1:0] converter_channel_n_o,
	// Serial peripheral interface
	input  wire logic                          serial_periph_on_i,
	input  wire logic                          spi_controller_role_i,
	input  wire logic                          spi_clk_out_i,
	input  wire logic                          spi_ctrl_data_out_i,
	input  wire logic                          spi_tgt_data_out_i,
	output logic                               spi_clk_in_o,
	output logic                               spi_ctrl_data_in_o,
	output logic                               spi_tgt_data_in_o,
	output logic                               spi_select_in_o,
	output logic                               spi_tgt_active_o,
	// Timer 0 compare output
	input  wire logic                          compare0_out_en_i,
	input  wire logic                          compare0_output_i,
	// Comparator analog inputs
	output logic                               comparator_pos_input_o,
	output logic                               comparator_neg_input_o,
	// External interrupt 2
	input  wire logic                          ext_irq2_en_i,
	output logic                               ext_irq2_input_o,
	// Timer count sources
	output logic                               counter0_ext_source_o,
	output logic                               counter1_ext_source_o,
	// USART clock
	input  wire logic                          usart_sync_select_i,
	input  wire logic                          usart_clk_out_i,
	output logic                               usart_ext_clock_o,
	output logic                               usart_clk_is_output_o
);
	import pab_pkg::*;

	// True when the interface is switched on in the named role
	function automatic logic spi_in_role(input pab_spi_role_e role, input pab_spi_role_e want);
		spi_in_role = (role == want);
	endfunction

	// Decoded interface role
	pab_spi_role_e spi_role;

	// Role decode, off wins over the controller bit
	always_comb begin
		unique case ({serial_periph_on_i, spi_controller_role_i})
			2'b11:   spi_role = PAB_SPI_CTRL;
			2'b10:   spi_role = PAB_SPI_TGT;
			default: spi_role = PAB_SPI_OFF;   // Controller bit ignored while off
		endcase
	end

	// Role flags used by the tables below
	logic spi_ctrl_on;    // Enabled as controller
	logic spi_tgt_on;     // Enabled as target

	assign spi_ctrl_on = spi_in_role(spi_role, PAB_SPI_CTRL);
	assign spi_tgt_on  = spi_in_role(spi_role, PAB_SPI_TGT);

	// Port B override vectors, one bit per pin
	logic [PAB_PORT_W-1:0] pb_pu_oe;    // Pull-up override enable
	logic [PAB_PORT_W-1:0] pb_pu_ov;    // Pull-up override value
	logic [PAB_PORT_W-1:0] pb_dd_oe;    // Direction override enable
	logic [PAB_PORT_W-1:0] pb_dd_ov;    // Direction override value
	logic [PAB_PORT_W-1:0] pb_pv_oe;    // Value override enable
	logic [PAB_PORT_W-1:0] pb_pv_ov;    // Value override value
	logic [PAB_PORT_W-1:0] pb_die_oe;   // Input buffer override enable
	logic [PAB_PORT_W-1:0] pb_die_ov;   // Input buffer override value

	// Forced-input masks of the four serial pins, by role
	logic spi_clk_forced;   // Clock pin forced to input
	logic spi_ci_forced;    // Controller-in pin forced to input
	logic spi_co_forced;    // Controller-out pin forced to input
	logic spi_sel_forced;   // Select pin forced to input

	assign spi_clk_forced = spi_tgt_on;
	assign spi_ci_forced  = spi_ctrl_on;
	assign spi_co_forced  = spi_tgt_on;
	assign spi_sel_forced = spi_tgt_on;

	// Serial pins: pull-up and direction enables rise together in the input role
	assign pb_pu_oe[PAB_PB_SPI_CLK] = spi_clk_forced;
	assign pb_pu_oe[PAB_PB_SPI_CI]  = spi_ci_forced;
	assign pb_pu_oe[PAB_PB_SPI_CO]  = spi_co_forced;
	assign pb_pu_oe[PAB_PB_SPI_SEL] = spi_sel_forced;
	assign pb_dd_oe[PAB_PB_SPI_CLK] = spi_clk_forced;
	assign pb_dd_oe[PAB_PB_SPI_CI]  = spi_ci_forced;
	assign pb_dd_oe[PAB_PB_SPI_CO]  = spi_co_forced;
	assign pb_dd_oe[PAB_PB_SPI_SEL] = spi_sel_forced;

	// Generate for the per-pin pull-up value and zero direction value
	for (genvar s = PAB_PB_SPI_SEL; s <= PAB_PB_SPI_CLK; s++) begin : g_spi_pu
		// Output bit still steers the pull-up unless pull-ups are globally off
		assign pb_pu_ov[s] = port_b_output_bit_i[s] & ~global_pullup_off_i;
		assign pb_dd_ov[s] = PAB_SPI_DIR_OVR_VAL;
		assign pb_die_oe[s] = 1'b0;
		assign pb_die_ov[s] = 1'b0;
	end

	// Value overrides: the pins the interface drives in its current role
	assign pb_pv_oe[PAB_PB_SPI_CLK] = spi_ctrl_on;
	assign pb_pv_ov[PAB_PB_SPI_CLK] = spi_clk_out_i;
	assign pb_pv_oe[PAB_PB_SPI_CI]  = spi_tgt_on;
	assign pb_pv_ov[PAB_PB_SPI_CI]  = spi_tgt_data_out_i;
	assign pb_pv_oe[PAB_PB_SPI_CO]  = spi_ctrl_on;
	assign pb_pv_ov[PAB_PB_SPI_CO]  = spi_ctrl_data_out_i;
	assign pb_pv_oe[PAB_PB_SPI_SEL] = 1'b0;                  // Interface never drives select; port bits drive it outside target role
	assign pb_pv_ov[PAB_PB_SPI_SEL] = 1'b0;

	// Lower four pins never touch pull-up or direction; the bits decide
	for (genvar l = PAB_PB_CNT0; l <= PAB_PB_CMP0; l++) begin : g_low_fixed
		assign pb_pu_oe[l] = 1'b0;
		assign pb_pu_ov[l] = 1'b0;
		assign pb_dd_oe[l] = 1'b0;
		assign pb_dd_ov[l] = 1'b0;
	end

	// Compare output: direction bit must be set by software to reach the pad
	assign pb_pv_oe[PAB_PB_CMP0]  = compare0_out_en_i;
	assign pb_pv_ov[PAB_PB_CMP0]  = compare0_output_i;
	assign pb_die_oe[PAB_PB_CMP0] = 1'b0;
	assign pb_die_ov[PAB_PB_CMP0] = 1'b0;

	// Interrupt 2: input buffer held on so the pin can wake from deep sleep
	assign pb_pv_oe[PAB_PB_IRQ2]  = 1'b0;
	assign pb_pv_ov[PAB_PB_IRQ2]  = 1'b0;
	assign pb_die_oe[PAB_PB_IRQ2] = ext_irq2_en_i;
	assign pb_die_ov[PAB_PB_IRQ2] = 1'b1;

	// Counter 1 source: plain input, nothing overridden
	assign pb_pv_oe[PAB_PB_CNT1]  = 1'b0;
	assign pb_pv_ov[PAB_PB_CNT1]  = 1'b0;
	assign pb_die_oe[PAB_PB_CNT1] = 1'b0;
	assign pb_die_ov[PAB_PB_CNT1] = 1'b0;

	// USART clock: value override only in synchronous mode
	assign pb_pv_oe[PAB_PB_CNT0]  = usart_sync_select_i;
	assign pb_pv_ov[PAB_PB_CNT0]  = usart_clk_out_i;
	assign pb_die_oe[PAB_PB_CNT0] = 1'b0;
	assign pb_die_ov[PAB_PB_CNT0] = 1'b0;

	// Full 16-pin vectors, port A in the low half with every override zero
	logic [PAB_NUM_PINS-1:0] all_dir;      // Direction bits
	logic [PAB_NUM_PINS-1:0] all_out;      // Output bits
	logic [PAB_NUM_PINS-1:0] all_pad;      // Pad levels
	logic [PAB_NUM_PINS-1:0] all_pu_oe;
	logic [PAB_NUM_PINS-1:0] all_pu_ov;
	logic [PAB_NUM_PINS-1:0] all_dd_oe;
	logic [PAB_NUM_PINS-1:0] all_dd_ov;
	logic [PAB_NUM_PINS-1:0] all_pv_oe;
	logic [PAB_NUM_PINS-1:0] all_pv_ov;
	logic [PAB_NUM_PINS-1:0] all_die_oe;
	logic [PAB_NUM_PINS-1:0] all_die_ov;

	assign all_dir    = {port_b_direction_bit_i, port_a_direction_bits_i};
	assign all_out    = {port_b_output_bit_i, port_a_output_bits_i};
	assign all_pad    = {port_b_pad_i, port_a_pad_i};
	assign all_pu_oe  = {pb_pu_oe, PAB_RST_PORT};
	assign all_pu_ov  = {pb_pu_ov, PAB_RST_PORT};
	assign all_dd_oe  = {pb_dd_oe, PAB_RST_PORT};
	assign all_dd_ov  = {pb_dd_ov, PAB_RST_PORT};
	assign all_pv_oe  = {pb_pv_oe, PAB_RST_PORT};
	assign all_pv_ov  = {pb_pv_ov, PAB_RST_PORT};
	assign all_die_oe = {pb_die_oe, PAB_RST_PORT};
	assign all_die_ov = {pb_die_ov, PAB_RST_PORT};

	// Resolved per-pin results
	logic [PAB_NUM_PINS-1:0] res_pullup;   // Pull-up on
	logic [PAB_NUM_PINS-1:0] res_oe;       // Driver enabled
	logic [PAB_NUM_PINS-1:0] res_val;      // Driven level
	logic [PAB_NUM_PINS-1:0] res_din;      // Digital input after clamp

	// One resolver per pin
	for (genvar p = 0; p < PAB_NUM_PINS; p++) begin : g_pin
		pab_pin_ctrl u_pin (
			.dir_bit_i                (all_dir[p]),
			.out_bit_i                (all_out[p]),
			.global_pullup_off_i      (global_pullup_off_i),
			.deep_sleep_i             (deep_sleep_i),
			.pullup_override_en_i     (all_pu_oe[p]),
			.pullup_override_val_i    (all_pu_ov[p]),
			.dir_override_en_i        (all_dd_oe[p]),
			.dir_override_val_i       (all_dd_ov[p]),
			.value_override_en_i      (all_pv_oe[p]),
			.value_override_val_i     (all_pv_ov[p]),
			.input_buf_override_en_i  (all_die_oe[p]),
			.input_buf_override_val_i (all_die_ov[p]),
			.pad_level_i              (all_pad[p]),
			.pullup_en_o              (res_pullup[p]),
			.drive_en_o               (res_oe[p]),
			.drive_val_o              (res_val[p]),
			.pin_input_to_function_o  (res_din[p])
		);
	end

	// Port B digital inputs, named for the functions they feed
	logic [PAB_PORT_W-1:0] pb_din;
	assign pb_din = res_din[PAB_NUM_PINS-1:PAB_PB_BASE];

	// Pad-facing registers
	logic [PAB_NUM_PINS-1:0] pad_val_r;
	logic [PAB_NUM_PINS-1:0] pad_oe_r;
	logic [PAB_NUM_PINS-1:0] pullup_r;
	logic [PAB_NUM_PINS-1:0] pin_read_r;
	logic [PAB_PORT_W-1:0]   analog_r;     // Port A analog path samples

	// Driven level parked low when the driver is off, so outputs never float
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pad_val_r <= PAB_RST_PINS;
			pad_oe_r  <= PAB_RST_PINS;
		end else begin
			pad_val_r <= res_val & res_oe;
			pad_oe_r  <= res_oe;
		end
	end

	// Pull-ups and port read-back
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pullup_r   <= PAB_RST_PINS;   // Pull-ups off during reset
			pin_read_r <= PAB_RST_PINS;
		end else begin
			pullup_r   <= res_pullup;
			pin_read_r <= res_din;
		end
	end

	// Analog path mirrors the raw pad level, independent of the input buffer
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			analog_r <= PAB_RST_PORT;
		end else begin
			analog_r <= port_a_pad_i;
		end
	end

	// Function inputs, each one register stage from the pad
	logic spi_clk_in_r;
	logic spi_ctrl_din_r;
	logic spi_tgt_din_r;
	logic spi_sel_r;
	logic spi_tgt_act_r;
	logic cmp_pos_r;
	logic cmp_neg_r;
	logic irq2_r;
	logic cnt0_r;
	logic cnt1_r;
	logic usart_clk_r;
	logic usart_dir_r;

	// Serial interface inputs; select is active low in target role
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			spi_clk_in_r   <= PAB_RST_BIT;
			spi_ctrl_din_r <= PAB_RST_BIT;
			spi_tgt_din_r  <= PAB_RST_BIT;
			spi_sel_r      <= PAB_RST_BIT;
			spi_tgt_act_r  <= PAB_RST_BIT;
		end else begin
			spi_clk_in_r   <= pb_din[PAB_PB_SPI_CLK];
			spi_ctrl_din_r <= pb_din[PAB_PB_SPI_CI];
			spi_tgt_din_r  <= pb_din[PAB_PB_SPI_CO];
			spi_sel_r      <= pb_din[PAB_PB_SPI_SEL];
			spi_tgt_act_r  <= spi_tgt_on & ~pb_din[PAB_PB_SPI_SEL];
		end
	end

	// Comparator taps see the raw pad; software keeps the port quiet there
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmp_pos_r <= PAB_RST_BIT;
			cmp_neg_r <= PAB_RST_BIT;
		end else begin
			cmp_pos_r <= port_b_pad_i[PAB_PB_IRQ2];
			cmp_neg_r <= port_b_pad_i[PAB_PB_CMP0];
		end
	end

	// Timer, interrupt and USART clock inputs
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq2_r      <= PAB_RST_BIT;
			cnt0_r      <= PAB_RST_BIT;
			cnt1_r      <= PAB_RST_BIT;
			usart_clk_r <= PAB_RST_BIT;
			usart_dir_r <= PAB_RST_BIT;
		end else begin
			irq2_r      <= pb_din[PAB_PB_IRQ2];
			cnt0_r      <= pb_din[PAB_PB_CNT0];
			cnt1_r      <= pb_din[PAB_PB_CNT1];
			usart_clk_r <= pb_din[PAB_PB_CNT0] & usart_sync_select_i;
			usart_dir_r <= usart_sync_select_i &
			               port_b_direction_bit_i[PAB_PB_CNT0];
		end
	end

	// Output wiring
	assign port_a_pad_o          = pad_val_r[PAB_PB_BASE-1:0];
	assign port_a_pad_oe_o       = pad_oe_r[PAB_PB_BASE-1:0];
	assign port_a_pullup_o       = pullup_r[PAB_PB_BASE-1:0];
	assign port_a_pin_read_o     = pin_read_r[PAB_PB_BASE-1:0];
	assign port_b_pad_o          = pad_val_r[PAB_NUM_PINS-1:PAB_PB_BASE];
	assign port_b_pad_oe_o       = pad_oe_r[PAB_NUM_PINS-1:PAB_PB_BASE];
	assign port_b_pullup_o       = pullup_r[PAB_NUM_PINS-1:PAB_PB_BASE];
	assign port_b_pin_read_o     = pin_read_r[PAB_NUM_PINS-1:PAB_PB_BASE];
	assign converter_channel_n_o = analog_r;
	assign spi_clk_in_o          = spi_clk_in_r;
	assign spi_ctrl_data_in_o    = spi_ctrl_din_r;
	assign spi_tgt_data_in_o     = spi_tgt_din_r;
	assign spi_select_in_o       = spi_sel_r;
	assign spi_tgt_active_o      = spi_tgt_act_r;
	assign comparator_pos_input_o = cmp_pos_r;
	assign comparator_neg_input_o = cmp_neg_r;
	assign ext_irq2_input_o      = irq2_r;
	assign counter0_ext_source_o = cnt0_r;
	assign counter1_ext_source_o = cnt1_r;
	assign usart_ext_clock_o     = usart_clk_r;
	assign usart_clk_is_output_o = usart_dir_r;

endmodule // pab_port_mux

// ---- test/pab_port_mux_assertions.sv ----
/* Checker for pab_port_mux: pin override relations, one cycle after the inputs.
   Assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/1ps
module pab_port_mux_chk (
	// Clock, reset and controls
	input wire logic       sys_clk_i, rst_b_i, global_pullup_off_i, deep_sleep_i,
	input wire logic       serial_periph_on_i, spi_controller_role_i, ext_irq2_en_i,
	input wire logic       usart_sync_select_i,
	// Port register bits and pads
	input wire logic [7:0] port_a_direction_bits_i, port_a_output_bits_i, port_b_pad_i,
	input wire logic [7:0] port_b_direction_bit_i, port_b_output_bit_i,
	// Registered outputs
	input wire logic [7:0] port_a_pad_oe_o, port_a_pullup_o, port_b_pad_oe_o, port_b_pullup_o,
	input wire logic       spi_tgt_active_o, ext_irq2_input_o, usart_clk_is_output_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Every antecedent needs a sampled edge out of reset, so the first edge stays quiet
	property p_pa_oe;
		$past(rst_b_i) |-> port_a_pad_oe_o == $past(port_a_direction_bits_i);
	endproperty
	a_pa_oe: assert property (p_pa_oe)
		else $error("port A drive enable wrong");
	property p_pa_pu;
		$past(rst_b_i) |-> port_a_pullup_o == (~$past(port_a_direction_bits_i)
			& $past(port_a_output_bits_i) & {8{!$past(global_pullup_off_i)}});
	endproperty
	a_pa_pu: assert property (p_pa_pu)
		else $error("port A pull-up wrong");
	property p_tgt_oe;
		$past(rst_b_i) && $past(serial_periph_on_i) && !$past(spi_controller_role_i)
			|-> (port_b_pad_oe_o & 8'hB0) == 8'h00;
	endproperty
	a_tgt_oe: assert property (p_tgt_oe)
		else $error("target pins not forced to input");
	property p_ctl_oe;
		$past(rst_b_i) && $past(serial_periph_on_i) && $past(spi_controller_role_i)
			|-> !port_b_pad_oe_o[6];
	endproperty
	a_ctl_oe: assert property (p_ctl_oe)
		else $error("controller input pin driven");
	property p_tgt_pu;
		$past(rst_b_i) && $past(serial_periph_on_i) && !$past(spi_controller_role_i)
			|-> port_b_pullup_o[7] == ($past(port_b_output_bit_i[7]) && !$past(global_pullup_off_i));
	endproperty
	a_tgt_pu: assert property (p_tgt_pu)
		else $error("forced-input pull-up wrong");
	property p_tgt_act;
		$past(rst_b_i) |-> spi_tgt_active_o == ($past(serial_periph_on_i)
			&& !$past(spi_controller_role_i)
			&& !($past(port_b_pad_i[4]) && !$past(deep_sleep_i)));
	endproperty
	a_tgt_act: assert property (p_tgt_act)
		else $error("target active flag wrong");
	property p_irq2;
		$past(rst_b_i) |-> ext_irq2_input_o == ($past(port_b_pad_i[2])
			&& ($past(ext_irq2_en_i) || !$past(deep_sleep_i)));
	endproperty
	a_irq2: assert property (p_irq2)
		else $error("interrupt 2 input wrong");
	property p_usart_dir;
		$past(rst_b_i) |-> usart_clk_is_output_o
			== ($past(usart_sync_select_i) && $past(port_b_direction_bit_i[0]));
	endproperty
	a_usart_dir: assert property (p_usart_dir)
		else $error("USART clock direction wrong");
	c_tgt: cover property (spi_tgt_active_o);
	c_ctl: cover property (serial_periph_on_i && spi_controller_role_i);
	c_irq: cover property (ext_irq2_en_i && deep_sleep_i && ext_irq2_input_o);
endmodule // pab_port_mux_chk
bind pab_port_mux pab_port_mux_chk pab_port_mux_chk_inst (.*);

// ---- test/pab_periph_model.sv ----
/* Peripheral side model: serial, compare and USART clock levels.
   Assumes it shares the bench clock and reset. */
`timescale 1ns/1ps
module pab_periph_model (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rst_b_i,
	// Levels the peripherals want on their pins
	output logic      spi_clk_o,
	output logic      spi_ctrl_data_o,
	output logic      spi_tgt_data_o,
	output logic      compare0_o,
	output logic      usart_clk_o
);
	logic [2:0] cnt_r; // Pattern source, so a stale serial clock or compare level never passes for a fresh one
	// Free-running count, moves every cycle
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= 3'h0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end
	assign spi_clk_o       = cnt_r[0];
	assign spi_ctrl_data_o = cnt_r[1];
	assign spi_tgt_data_o  = cnt_r[2];
	assign compare0_o      = ~cnt_r[0]; // Comparator pins left as inputs without pull-up
	assign usart_clk_o     = cnt_r[0] ^ cnt_r[1];
endmodule // pab_periph_model

// ---- test/test_pab_port_mux.sv ----
/* Self-checking bench for pab_port_mux with the peripheral model on the far side.
   Assumes one 40 MHz clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
module test_pab_port_mux;
	import pab_pkg::*;
	logic       sys_clk_i = 1'h0, rst_b_i = 1'h0;
	logic [7:0] port_a_direction_bits_i, port_a_output_bits_i, port_a_pad_i, port_a_pad_o;
	logic [7:0] port_a_pad_oe_o, port_a_pullup_o, port_a_pin_read_o, converter_channel_n_o;
	logic [7:0] port_b_direction_bit_i, port_b_output_bit_i, port_b_pad_i, port_b_pad_o;
	logic [7:0] port_b_pad_oe_o, port_b_pullup_o, port_b_pin_read_o;
	logic       global_pullup_off_i, deep_sleep_i, serial_periph_on_i, spi_controller_role_i;
	logic       spi_clk_out_i, spi_ctrl_data_out_i, spi_tgt_data_out_i, spi_clk_in_o;
	logic       spi_ctrl_data_in_o, spi_tgt_data_in_o, spi_select_in_o, spi_tgt_active_o;
	logic       compare0_out_en_i, compare0_output_i, comparator_pos_input_o;
	logic       comparator_neg_input_o, ext_irq2_en_i, ext_irq2_input_o, counter0_ext_source_o;
	logic       counter1_ext_source_o, usart_sync_select_i, usart_clk_out_i, usart_ext_clock_o;
	logic       usart_clk_is_output_o;
	logic [4:0] snap;                                  // Peripheral levels the design samples
	logic [7:0] oe_x [3] = '{8'hFF, 8'h4F, 8'hBF};     // Drive enables: off, target, controller
	logic [7:0] pu_x [3] = '{8'h00, 8'hB0, 8'h40};     // Pull-ups per role
	int         miscompares = 0, check_count = 0;
	pab_port_mux pab_port_mux_inst (.*);
	pab_periph_model pab_periph_model_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.spi_clk_o(spi_clk_out_i), .spi_ctrl_data_o(spi_ctrl_data_out_i),
		.spi_tgt_data_o(spi_tgt_data_out_i), .compare0_o(compare0_output_i),
		.usart_clk_o(usart_clk_out_i));
	always #12.5 sys_clk_i = ~sys_clk_i;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Let the edge's updates land, note the model levels, then wait out the one-cycle latency
	task automatic go;
		#1;
		snap = {spi_clk_out_i, spi_ctrl_data_out_i, spi_tgt_data_out_i, compare0_output_i,
			usart_clk_out_i};
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic results;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Watchdog, far beyond the roughly 36 cycles the sequence needs
	initial begin
		#20000;
		miscompares++;
		results;
	end
	initial begin
		{port_a_direction_bits_i, port_a_output_bits_i, port_a_pad_i} = 24'h000000;
		{port_b_direction_bit_i, port_b_output_bit_i, port_b_pad_i} = 24'h000000;
		{global_pullup_off_i, deep_sleep_i, serial_periph_on_i, spi_controller_role_i} = 4'h0;
		{compare0_out_en_i, ext_irq2_en_i, usart_sync_select_i} = 3'h0;
		repeat (16) @(posedge sys_clk_i);
		rst_b_i <= 1'h1;
		@(posedge sys_clk_i);
		port_a_direction_bits_i <= 8'h0F;
		port_a_output_bits_i <= 8'h3C; // Held still from here on, a conversion may run
		port_a_pad_i <= 8'hA5;
		go;
		chk(port_a_pad_oe_o, 8'h0F);
		chk(port_a_pullup_o, 8'h30);
		chk(port_a_pad_o, 8'h0C);
		chk(port_a_pin_read_o, 8'hA5);
		@(posedge sys_clk_i);
		global_pullup_off_i <= 1'h1;
		deep_sleep_i <= 1'h1;
		go;
		chk(port_a_pullup_o, 8'h00);
		chk(port_a_pin_read_o, 8'h00);
		chk(converter_channel_n_o, 8'hA5);
		// Serial roles: off with the role bit set, target, controller
		for (int r = 0; r < 3; r++) begin
			@(posedge sys_clk_i);
			{global_pullup_off_i, deep_sleep_i} <= 2'h0;
			serial_periph_on_i <= (r != 0);
			spi_controller_role_i <= (r != 1);
			port_b_direction_bit_i <= 8'hFF;
			port_b_output_bit_i <= 8'hFF;
			port_b_pad_i <= 8'h40;
			go;
			chk(port_b_pad_oe_o, oe_x[r]);
			chk(port_b_pullup_o, pu_x[r]);
			chk(port_b_pad_o, (r == 0) ? 8'hFF : (r == 1) ? {1'h0, snap[2], 6'h0F} : {snap[4], 1'h0, snap[3], 5'h1F});
			chk({4'h0, spi_clk_in_o, spi_ctrl_data_in_o, spi_select_in_o, spi_tgt_active_o}, {7'h02, r == 1});
		end
		@(posedge sys_clk_i);
		spi_controller_role_i <= 1'h0;
		port_b_pad_i <= 8'h10;
		global_pullup_off_i <= 1'h1;
		go;
		chk({5'h00, spi_tgt_active_o, spi_select_in_o, spi_tgt_data_in_o}, 8'h02);
		chk(port_b_pullup_o, 8'h00);
		@(posedge sys_clk_i);
		{global_pullup_off_i, serial_periph_on_i} <= 2'h0;
		compare0_out_en_i <= 1'h1;
		port_b_direction_bit_i <= 8'h08; // Software sets the direction bit
		port_b_output_bit_i <= 8'h00;
		go;
		chk(port_b_pad_o, {4'h0, snap[1], 3'h0});
		@(posedge sys_clk_i);
		compare0_out_en_i <= 1'h0;
		port_b_direction_bit_i <= 8'h00;
		port_b_pad_i <= 8'hFF;
		deep_sleep_i <= 1'h1;
		ext_irq2_en_i <= 1'h1;
		go;
		chk(port_b_pin_read_o, 8'h04);
		chk({6'h00, counter1_ext_source_o, counter0_ext_source_o}, 8'h00);
		chk({5'h00, comparator_neg_input_o, ext_irq2_input_o, comparator_pos_input_o}, 8'h07);
		@(posedge sys_clk_i);
		{deep_sleep_i, ext_irq2_en_i} <= 2'h0;
		usart_sync_select_i <= 1'h1;
		port_b_direction_bit_i <= 8'h01;
		port_b_pad_i <= 8'h01;
		go;
		chk(port_b_pad_o, {7'h00, snap[0]});
		chk({5'h00, usart_ext_clock_o, usart_clk_is_output_o, counter0_ext_source_o}, 8'h07);
		@(posedge sys_clk_i);
		usart_sync_select_i <= 1'h0;
		go;
		chk({port_b_pad_o[0], usart_ext_clock_o, usart_clk_is_output_o, counter0_ext_source_o, 4'h0}, 8'h10);
		results;
	end
endmodule // test_pab_port_mux
